//--- rtl/ofdmhc_mcs_decode.sv
// Module: modulation/coding code to scheme and scrambler seed decoder
`timescale 1ns/1ps
module ofdmhc_mcs_decode
	import ofdmhc_pkg::*;
(
	// Codes
	input wire logic [2:0] modulationCodingCode,
	input wire logic [1:0] seedCode,
	// Decoded
	output ofdmhc_scheme_t scheme,
	output logic [8:0] pnSeed
);

	always_comb begin
		scheme = '0;
		case (ofdmhc_mcs_t'(modulationCodingCode))
			MCS_BPSK12_REP4: begin
				scheme = '{2'd1, 1'b0, 3'd4};
			end
			MCS_BPSK12_REP2: begin
				scheme = '{2'd1, 1'b0, 3'd2};
			end
			MCS_QPSK12_REP2: begin
				scheme = '{2'd2, 1'b0, 3'd2};
			end
			MCS_QPSK12: begin
				scheme = '{2'd2, 1'b0, 3'd1};
			end
			MCS_QPSK34: begin
				scheme = '{2'd2, 1'b1, 3'd1};
			end
			MCS_QAM16_12: begin
				scheme = '{2'd3, 1'b0, 3'd1};
			end
			MCS_QAM16_34: begin
				scheme = '{2'd3, 1'b1, 3'd1};
			end
			default: begin
				// Code 7 has no scheme; report all zero
				scheme = '0;
			end
		endcase
	end

	always_comb begin
		case (seedCode)
			2'h0: pnSeed = SEED_CODE0;
			2'h1: pnSeed = SEED_CODE1;
			2'h2: pnSeed = SEED_CODE2;
			default: pnSeed = SEED_CODE3;
		endcase
	end

endmodule

//--- rtl/ofdmhc_pkg.sv
// Package: register map, fields, reset values and encodings of the OFDM header config bank
package ofdmhc_pkg;

	// ****************************************
	// Register indices on the control port
	// ****************************************
	localparam logic [1:0] REG_TX_HEADER_SETUP = 2'h0;
	localparam logic [1:0] REG_RX_HEADER_STATUS = 2'h1;
	localparam logic [1:0] REG_PHY_SETUP = 2'h2;
	localparam logic [1:0] REG_TEST_SWITCHES = 2'h3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] TX_HEADER_SETUP_RST = 8'h00;
	localparam logic [7:0] RX_HEADER_STATUS_RST = 8'h00;
	localparam logic [7:0] PHY_SETUP_RST = 8'h00;
	localparam logic [7:0] TEST_SWITCHES_RST = 8'h00;

	// Writable bits per register; others are status or reserved
	localparam logic [7:0] TX_HEADER_WMASK = 8'hf7;
	localparam logic [7:0] RX_HEADER_WMASK = 8'h08;
	localparam logic [7:0] PHY_SETUP_WMASK = 8'h3f;
	localparam logic [7:0] TEST_SWITCHES_WMASK = 8'hff;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int HDR_RSV21_POS = 7;
	localparam int HDR_RSV18_POS = 6;
	localparam int HDR_RSV17_POS = 5;
	localparam int HDR_RSV5_POS = 4;
	localparam int SPUR_POS = 3;
	localparam int RXSEED_POS = 6;
	localparam int TXSEED_POS = 4;
	localparam int LOWOFS_POS = 3;
	localparam int INTLV_POS = 2;
	localparam int PTHR_POS = 5;
	localparam int RXOVR_POS = 4;

	// Power step that restarts sync under receiver override, in dB
	localparam int OVERRIDE_STEP_DB = 12;
	localparam logic [7:0] OVERRIDE_STEP = 8'd12;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [2:0] {
		MCS_BPSK12_REP4 = 3'h0,
		MCS_BPSK12_REP2 = 3'h1,
		MCS_QPSK12_REP2 = 3'h2,
		MCS_QPSK12 = 3'h3,
		MCS_QPSK34 = 3'h4,
		MCS_QAM16_12 = 3'h5,
		MCS_QAM16_34 = 3'h6,
		MCS_UNDEF = 3'h7
	} ofdmhc_mcs_t;

	localparam logic [8:0] SEED_CODE0 = 9'h017;
	localparam logic [8:0] SEED_CODE1 = 9'h177;
	localparam logic [8:0] SEED_CODE2 = 9'h01c;
	localparam logic [8:0] SEED_CODE3 = 9'h17c;

	// Decoded modulation scheme handed to the modem
	typedef struct packed {
		logic [1:0] bitsPerCarrier;
		logic codeRateThreeQuarter;
		logic [2:0] freqRepetition;
	} ofdmhc_scheme_t;

	// Outgoing header fields
	typedef struct packed {
		logic reservedHdrBitTwentyone;
		logic reservedHdrBitEighteen;
		logic reservedHdrBitSeventeen;
		logic reservedHdrBitFive;
		logic [4:0] rateField;
		logic [1:0] scramblerField;
	} ofdmhc_hdr_t;

	// Receive control states
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_FRAME = 3'b010,
		RX_RESTART = 3'b100
	} ofdmhc_rxst_t;

endpackage

//--- rtl/ofdmhc_regs.sv
// Module: OFDM PHY header configuration and status register bank
`timescale 1ns/1ps
// What this block does
// [R1] Software-written reserved header bits 21, 18, 17 and 5 go unchanged into the outgoing header.
// [R2] The 3-bit transmit code fills the low rate-field bits and the upper rate bits are zero.
// [R3] Codes 0 to 6 decode to BPSK/QPSK/16-QAM schemes with their rates and repetitions.
// [R4] Receive reserved bits, rate code and seed are loaded at the frame start event.
// [R5] The receive status register shows the reserved bits of the last frame, read-only.
// [R6] Bit 3 of the receive status register is writable and enables spur compensation.
// [R7] The receive code field reports the low three rate bits of the last frame.
// [R8] The receive seed field mirrors the received scrambler field and picks the descrambler seed.
// [R9] The transmit seed field picks the scrambler seed and fills the outgoing scrambler field.
// [R10] Software sets low-offset reception only when the offset is surely below 57.3 kHz.
// [R11] The interleave bit chooses a depth of one symbol or of the spreading factor.
// [R12] Bandwidth codes 0 to 3 select options 1 to 4, with code 0 the default.
// [R13] The 3-bit preamble threshold drives the detector, lower meaning more sensitive.
// [R14] With override on during reception, a power rise above 12 dB per symbol restarts sync.
// [R15] The override bit is zero for disabled and one for enabled.
// [R16] Software does not program the undefined modulation code 7.
module ofdmhc_regs
	import ofdmhc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register access from the control interface
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// Receiver header status, valid with the frame start pulse
	input wire logic rxFrameStartIrq,
	input wire logic [4:0] rxRateField,
	input wire logic [1:0] rxScramblerField,
	input wire logic [3:0] rxReservedBits,
	// Receiver activity and per-symbol power in dB
	input wire logic rxFrameActive,
	input wire logic symbolStrobe,
	input wire logic [7:0] symbolPowerDb,
	// Transmit header and scheme
	output ofdmhc_hdr_t txHeader,
	output ofdmhc_scheme_t txScheme,
	output logic [8:0] txPnSeed,
	// Receive scheme and descrambler seed
	output ofdmhc_scheme_t rxScheme,
	output logic [8:0] rxPnSeed,
	// Modem configuration
	output logic [1:0] bandwidthOption,
	output logic interleaveDepthSelect,
	output logic lowOffsetReception,
	output logic spurCompensationEnable,
	output logic [2:0] preambleThreshold,
	output logic receiverOverrideEnable,
	output logic rxSyncRestart
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] txHdrSetup_ff;
	logic [7:0] rxHdrStatus_ff;
	logic [7:0] phySetup_ff;
	logic [7:0] testSwitches_ff;
	logic [7:0] regRdata_ff;
	logic [7:0] nxt_rxHdrStatus;
	logic [7:0] nxt_phySetup;
	logic [7:0] nxt_regRdata;

	wire wrTx = regWrite && (regAddr == REG_TX_HEADER_SETUP);
	wire wrRx = regWrite && (regAddr == REG_RX_HEADER_STATUS);
	wire wrPhy = regWrite && (regAddr == REG_PHY_SETUP);
	wire wrSw = regWrite && (regAddr == REG_TEST_SWITCHES);

	wire [7:0] txWrVal = regWdata & TX_HEADER_WMASK;
	wire [7:0] swWrVal = regWdata & TEST_SWITCHES_WMASK;

	// [R5] Status bits read-only
	// Writes touch only writable bits; status bits keep their value
	wire [7:0] rxAfterWr = wrRx ?
		((rxHdrStatus_ff & ~RX_HEADER_WMASK) | (regWdata & RX_HEADER_WMASK)) : rxHdrStatus_ff;
	wire [7:0] phyAfterWr = wrPhy ?
		((phySetup_ff & ~PHY_SETUP_WMASK) | (regWdata & PHY_SETUP_WMASK)) : phySetup_ff;

	// [R4] Status capture on frame start
	// Capture wins over a software write to the same status bits, which are read-only anyway
	assign nxt_rxHdrStatus = rxFrameStartIrq ?
		{rxReservedBits, rxAfterWr[SPUR_POS], rxRateField[2:0]} : rxAfterWr;
	// [R8] Received seed capture
	assign nxt_phySetup = rxFrameStartIrq ?
		{rxScramblerField, phyAfterWr[5:0]} : phyAfterWr;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			txHdrSetup_ff <= TX_HEADER_SETUP_RST;
		end else if (wrTx) begin
			txHdrSetup_ff <= txWrVal;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rxHdrStatus_ff <= RX_HEADER_STATUS_RST;
			phySetup_ff <= PHY_SETUP_RST;
		end else begin
			rxHdrStatus_ff <= nxt_rxHdrStatus;
			phySetup_ff <= nxt_phySetup;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			testSwitches_ff <= TEST_SWITCHES_RST;
		end else if (wrSw) begin
			testSwitches_ff <= swWrVal;
		end
	end

	// ****************************************
	// Read path, registered one cycle after the read strobe
	// ****************************************
	always_comb begin
		case (regAddr)
			REG_TX_HEADER_SETUP: nxt_regRdata = txHdrSetup_ff;
			REG_RX_HEADER_STATUS: nxt_regRdata = rxHdrStatus_ff;
			REG_PHY_SETUP: nxt_regRdata = phySetup_ff;
			default: nxt_regRdata = testSwitches_ff;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regRdata_ff <= 8'h00;
		end else if (regRead) begin
			regRdata_ff <= nxt_regRdata;
		end
	end
	assign regRdata = regRdata_ff;

	// ****************************************
	// Outgoing header and decoders
	// ****************************************
	// [R1] Reserved bits into header
	assign txHeader.reservedHdrBitTwentyone = txHdrSetup_ff[HDR_RSV21_POS];
	assign txHeader.reservedHdrBitEighteen = txHdrSetup_ff[HDR_RSV18_POS];
	assign txHeader.reservedHdrBitSeventeen = txHdrSetup_ff[HDR_RSV17_POS];
	assign txHeader.reservedHdrBitFive = txHdrSetup_ff[HDR_RSV5_POS];
	// [R2] Rate field zero-extended
	assign txHeader.rateField = {2'b00, txHdrSetup_ff[2:0]};
	// [R9] Scrambler field from seed select
	assign txHeader.scramblerField = phySetup_ff[TXSEED_POS +: 2];

	// [R3] Transmit code decode
	ofdmhc_mcs_decode u_txDecode (
		.modulationCodingCode(txHdrSetup_ff[2:0]),
		.seedCode(phySetup_ff[TXSEED_POS +: 2]),
		.scheme(txScheme),
		.pnSeed(txPnSeed)
	);

	// [R7] Receive code uses the same mapping
	ofdmhc_mcs_decode u_rxDecode (
		.modulationCodingCode(rxHdrStatus_ff[2:0]),
		.seedCode(phySetup_ff[RXSEED_POS +: 2]),
		.scheme(rxScheme),
		.pnSeed(rxPnSeed)
	);

	// [R12] Bandwidth option
	assign bandwidthOption = phySetup_ff[1:0];
	// [R11] Interleaver depth select
	assign interleaveDepthSelect = phySetup_ff[INTLV_POS];
	assign lowOffsetReception = phySetup_ff[LOWOFS_POS];
	// [R6] Spur compensation enable
	assign spurCompensationEnable = rxHdrStatus_ff[SPUR_POS];
	// [R13] Detector threshold
	assign preambleThreshold = testSwitches_ff[PTHR_POS +: 3];
	// [R15] Override enable bit
	assign receiverOverrideEnable = testSwitches_ff[RXOVR_POS];

	// ****************************************
	// Receiver override monitor
	// ****************************************
	ofdmhc_rxst_t rxState_ff;
	ofdmhc_rxst_t nxt_rxState;
	logic [7:0] lastPower_ff;
	logic havePower_ff;

	// Compared as a 9-bit sum so the threshold cannot wrap past 255
	wire [8:0] powerLimit = {1'b0, lastPower_ff} + {1'b0, OVERRIDE_STEP};
	wire powerJump = symbolStrobe && havePower_ff && ({1'b0, symbolPowerDb} > powerLimit);

	always_comb begin
		nxt_rxState = rxState_ff;
		case (rxState_ff)
			RX_IDLE: begin
				if (rxFrameActive) nxt_rxState = RX_FRAME;
			end
			RX_FRAME: begin
				// [R14] Restart on a large power step
				if (!rxFrameActive) nxt_rxState = RX_IDLE;
				else if (receiverOverrideEnable && powerJump) nxt_rxState = RX_RESTART;
			end
			RX_RESTART: begin
				nxt_rxState = RX_IDLE;
			end
			default: begin
				nxt_rxState = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rxState_ff <= RX_IDLE;
		end else begin
			rxState_ff <= nxt_rxState;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || rxState_ff != RX_FRAME) begin
			havePower_ff <= 1'b0;
			lastPower_ff <= 8'h00;
		end else if (symbolStrobe) begin
			havePower_ff <= 1'b1;
			lastPower_ff <= symbolPowerDb;
		end
	end

	assign rxSyncRestart = (rxState_ff == RX_RESTART);

	// ****************************************
	// Checks
	// ****************************************
	chk_rx_capture_load: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		rxFrameStartIrq |=> rxHdrStatus_ff[2:0] == $past(rxRateField[2:0])
			&& rxHdrStatus_ff[7:4] == $past(rxReservedBits))
		else $error("receive status not captured at frame start");
	chk_rx_reserved_ro: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		!rxFrameStartIrq |=> $stable(rxHdrStatus_ff[7:4]))
		else $error("receive reserved bits changed without frame start");
	chk_rx_code_ro: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
		!rxFrameStartIrq |=> $stable(rxHdrStatus_ff[2:0]))
		else $error("receive code changed without frame start");
	chk_spur_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
		wrRx |=> spurCompensationEnable == $past(regWdata[SPUR_POS]))
		else $error("spur enable not written");
	chk_rx_seed_load: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		rxFrameStartIrq |=> phySetup_ff[7:6] == $past(rxScramblerField))
		else $error("receive seed not captured");
	chk_tx_rate_upper: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		txHeader.rateField[4:3] == 2'b00 && txHeader.rateField[2:0] == txHdrSetup_ff[2:0])
		else $error("transmit rate field wrong");
	chk_tx_reserved_bits: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
		wrTx |=> txHeader.reservedHdrBitFive == $past(regWdata[HDR_RSV5_POS])
			&& txHeader.reservedHdrBitTwentyone == $past(regWdata[HDR_RSV21_POS]))
		else $error("reserved header bits not taken from write");
	chk_tx_seed_zero: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
		phySetup_ff[5:4] == 2'h0 |-> txPnSeed == SEED_CODE0)
		else $error("transmit seed 0 wrong");
	chk_override_restart: assert property (@(posedge mclk) disable iff (sys_rst) // [R14]
		(rxState_ff == RX_FRAME && rxFrameActive && receiverOverrideEnable && powerJump)
			|=> rxSyncRestart ##1 !rxSyncRestart)
		else $error("override restart missing");
	chk_override_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
		!$past(receiverOverrideEnable) |-> !$rose(rxSyncRestart))
		else $error("restart while override disabled");
	chk_option_map: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
		wrPhy |=> bandwidthOption == $past(regWdata[1:0]) || $past(rxFrameStartIrq) == 1'b0
			&& bandwidthOption == $past(regWdata[1:0]))
		else $error("bandwidth option not written");
	chk_tx_rate_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		wrTx |=> txHeader.rateField == {2'b00, $past(regWdata[2:0])})
		else $error("transmit rate field not taken from write");
	chk_tx_scheme_top: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
		txHdrSetup_ff[2:0] == 3'h6 |-> txScheme.bitsPerCarrier == 2'd3
			&& txScheme.codeRateThreeQuarter && txScheme.freqRepetition == 3'd1)
		else $error("code 6 not decoded as 16-QAM three quarter");
	chk_tx_seed_field: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
		wrPhy |=> txHeader.scramblerField == $past(regWdata[TXSEED_POS +: 2]))
		else $error("transmit scrambler field not written");
	chk_rx_seed_map: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		phySetup_ff[RXSEED_POS +: 2] == 2'h1 |-> rxPnSeed == SEED_CODE1)
		else $error("receive seed code 1 wrong");
	chk_interleave_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
		wrPhy |=> interleaveDepthSelect == $past(regWdata[INTLV_POS]))
		else $error("interleave select not written");
	chk_threshold_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R13]
		wrSw |=> preambleThreshold == $past(regWdata[PTHR_POS +: 3]))
		else $error("preamble threshold not written");
	chk_override_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R15]
		wrSw |=> receiverOverrideEnable == $past(regWdata[RXOVR_POS]))
		else $error("override bit not written");
	chk_restart_in_frame: assert property (@(posedge mclk) disable iff (sys_rst) // [R14]
		rxSyncRestart |-> $past(rxFrameActive) && $past(receiverOverrideEnable))
		else $error("restart outside reception or with override off");

	cov_frame_start: cover property (@(posedge mclk) disable iff (sys_rst) rxFrameStartIrq);
	cov_restart: cover property (@(posedge mclk) disable iff (sys_rst) rxSyncRestart);
	cov_tx_write: cover property (@(posedge mclk) disable iff (sys_rst) wrTx ##1 wrPhy);
	cov_start_write: cover property (@(posedge mclk) disable iff (sys_rst) rxFrameStartIrq && wrRx);

endmodule

//--- tb/ofdmhc_regs_test.sv
// Testbench: register access, header capture and receiver override of the OFDM config bank
`timescale 1ns/1ps
module ofdmhc_regs_test;
	import ofdmhc_pkg::*;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic rxFrameStartIrq = 1'b0;
	logic [4:0] rxRateField = 5'h00;
	logic [1:0] rxScramblerField = 2'h0;
	logic [3:0] rxReservedBits = 4'h0;
	logic rxFrameActive = 1'b0;
	logic symbolStrobe = 1'b0;
	logic [7:0] symbolPowerDb = 8'h00;
	logic [7:0] regRdata;
	ofdmhc_hdr_t txHeader;
	ofdmhc_scheme_t txScheme, rxScheme;
	logic [8:0] txPnSeed, rxPnSeed;
	logic [1:0] bandwidthOption;
	logic [2:0] preambleThreshold;
	logic interleaveDepthSelect, lowOffsetReception, spurCompensationEnable;
	logic receiverOverrideEnable, rxSyncRestart;
	logic [8:0] seeds [4] = '{9'h017, 9'h177, 9'h01c, 9'h17c};
	int mismatches = 0;
	int totalChecks = 0;
	int cycles = 0;

	ofdmhc_regs i_dut (.mclk(mclk), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.rxFrameStartIrq(rxFrameStartIrq), .rxRateField(rxRateField),
		.rxScramblerField(rxScramblerField), .rxReservedBits(rxReservedBits),
		.rxFrameActive(rxFrameActive), .symbolStrobe(symbolStrobe),
		.symbolPowerDb(symbolPowerDb), .txHeader(txHeader), .txScheme(txScheme),
		.txPnSeed(txPnSeed), .rxScheme(rxScheme), .rxPnSeed(rxPnSeed),
		.bandwidthOption(bandwidthOption), .interleaveDepthSelect(interleaveDepthSelect),
		.lowOffsetReception(lowOffsetReception), .spurCompensationEnable(spurCompensationEnable),
		.preambleThreshold(preambleThreshold), .receiverOverrideEnable(receiverOverrideEnable),
		.rxSyncRestart(rxSyncRestart));

	always #4 mclk = ~mclk;

	// Ceiling well above the roughly 190 cycles the sequence needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			test_done();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done();
		if (mismatches == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWrite <= 1'b0;
		#1;
	endtask

	// Read data is registered, so it is looked at just after the taking edge
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge mclk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chk(16'(regRdata), 16'(exp), "read");
	endtask

	// Frame start pulse, optionally colliding with a status write
	task automatic frm(input logic [3:0] rb, input logic [4:0] rate, input logic [1:0] sc,
		input logic alsoWrite);
		@(posedge mclk);
		rxFrameStartIrq <= 1'b1;
		rxReservedBits <= rb;
		rxRateField <= rate;
		rxScramblerField <= sc;
		if (alsoWrite) begin
			regWrite <= 1'b1;
			regAddr <= REG_RX_HEADER_STATUS;
			regWdata <= 8'h00;
		end
		@(posedge mclk);
		rxFrameStartIrq <= 1'b0;
		regWrite <= 1'b0;
		#1;
	endtask

	// Two symbol strobes, then the restart pulses are counted over four cycles
	task automatic ovr(input logic act, input logic [7:0] p1, input logic [7:0] p2,
		input int expPulses);
		int n;
		n = 0;
		@(posedge mclk);
		rxFrameActive <= act;
		repeat (2) @(posedge mclk);
		symbolStrobe <= 1'b1;
		symbolPowerDb <= p1;
		@(posedge mclk);
		symbolPowerDb <= p2;
		@(posedge mclk);
		symbolStrobe <= 1'b0;
		repeat (4) begin
			#1;
			// An unknown counts as a pulse
			if (rxSyncRestart !== 1'b0)
				n++;
			@(posedge mclk);
		end
		rxFrameActive <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(16'(n), 16'(expPulses), "restart pulses");
	endtask

	function automatic ofdmhc_scheme_t exps(input logic [2:0] c);
		case (c)
			3'h0: exps = {2'd1, 1'b0, 3'd4};
			3'h1: exps = {2'd1, 1'b0, 3'd2};
			3'h2: exps = {2'd2, 1'b0, 3'd2};
			3'h3: exps = {2'd2, 1'b0, 3'd1};
			3'h4: exps = {2'd2, 1'b1, 3'd1};
			3'h5: exps = {2'd3, 1'b0, 3'd1};
			3'h6: exps = {2'd3, 1'b1, 3'd1};
			default: exps = '0;
		endcase
	endfunction

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		logic [7:0] d;
		logic [3:0] rb;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 4; a++)
			rd(2'(a), 8'h00);
		chk(16'(txPnSeed), 16'h017, "tx seed after reset");
		chk(16'(rxSyncRestart), 16'h0, "restart after reset");
		// Bit 3 of the transmit register is read-only
		// Code 7 never programmed
		for (int m = 0; m < 7; m++) begin
			rb = ~4'(m);
			wr(REG_TX_HEADER_SETUP, {rb, 1'b1, 3'(m)});
			chk(16'(txHeader), 16'({rb, 2'b00, 3'(m), 2'b00}), "tx header");
			chk(16'(txScheme), 16'(exps(3'(m))), "tx scheme");
			rd(REG_TX_HEADER_SETUP, {rb, 1'b0, 3'(m)});
		end
		for (int c = 0; c < 4; c++) begin
			d = {2'b11, 2'(c), 1'(c), 1'(c >> 1), 2'(c)};
			wr(REG_PHY_SETUP, d);
			chk(16'(txPnSeed), 16'(seeds[c]), "tx seed");
			chk(16'(txHeader.scramblerField), 16'(c), "tx scrambler field");
			chk(16'(bandwidthOption), 16'(c), "bandwidth");
			chk(16'(interleaveDepthSelect), 16'(c >> 1), "interleave");
			chk(16'(lowOffsetReception), 16'(c & 1), "low offset");
			rd(REG_PHY_SETUP, d & 8'h3f);
		end
		wr(REG_RX_HEADER_STATUS, 8'hff);
		rd(REG_RX_HEADER_STATUS, 8'h08);
		chk(16'(spurCompensationEnable), 16'h1, "spur enable");
		// The last frame collides with a write that clears the spur bit
		for (int m = 0; m < 8; m++) begin
			rb = 4'(m * 3);
			frm(rb, {2'b10, 3'(m)}, 2'(m), m == 7);
			rd(REG_RX_HEADER_STATUS, {rb, m != 7, 3'(m)});
			rd(REG_PHY_SETUP, {2'(m), 6'h3f});
			chk(16'(rxPnSeed), 16'(seeds[m & 3]), "rx seed");
			chk(16'(rxScheme), 16'(exps(3'(m))), "rx scheme");
		end
		chk(16'(spurCompensationEnable), 16'h0, "spur after write");
		wr(REG_TEST_SWITCHES, 8'ha5);
		rd(REG_TEST_SWITCHES, 8'ha5);
		chk(16'(preambleThreshold), 16'h5, "threshold");
		chk(16'(receiverOverrideEnable), 16'h0, "override off");
		ovr(1'b1, 8'd10, 8'd23, 0);
		wr(REG_TEST_SWITCHES, 8'h10);
		chk(16'(receiverOverrideEnable), 16'h1, "override on");
		chk(16'(preambleThreshold), 16'h0, "threshold zero");
		ovr(1'b1, 8'd10, 8'd23, 1);
		ovr(1'b1, 8'd10, 8'd22, 0);
		ovr(1'b0, 8'd10, 8'd50, 0);
		ovr(1'b1, 8'd200, 8'd255, 1);
		test_done();
	end
endmodule
